// ---- include/ssp_pkg.sv ----
// constants and carrier types of the smbus slave with packet error check
`default_nettype none
package ssp_pkg;
  // bus address of this slave
  localparam logic [6:0] DEV_ADDR_DEF = 7'h0B;
  // packet error check crc
  localparam logic [7:0] CRC_POLY     = 8'h07;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  // bit slots within one byte frame
  localparam logic [3:0] BIT_FIRST    = 4'h0;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_STEP     = 4'h1;
  // received byte positions after a write address
  localparam logic [2:0] IDX_CMD      = 3'h0;
  localparam logic [2:0] IDX_LO       = 3'h1;
  localparam logic [2:0] IDX_HI       = 3'h2;
  localparam logic [2:0] CNT_BYTE_WR  = 3'h3;
  localparam logic [2:0] CNT_WORD_WR  = 3'h4;
  localparam logic [2:0] CNT_MAX      = 3'h7;
  localparam logic [2:0] CNT_STEP     = 3'h1;
  // transmitted byte positions after a read address
  localparam logic [1:0] TX_LO        = 2'h0;
  localparam logic [1:0] TX_HI        = 2'h1;
  localparam logic [1:0] TX_PEC_WORD  = 2'h2;
  localparam logic [1:0] TX_END       = 2'h3;
  localparam logic [1:0] TX_STEP      = 2'h1;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  // link side protocol state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WR,
    ST_RD,
    ST_IGNORE
  } ssp_state_t;
  // committed write towards the user side
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] data;
    logic        is_word;
  } ssp_wr_t;
  // read answer from the user side
  typedef struct packed {
    logic [15:0] data;
    logic        is_word;
  } ssp_rd_t;
endpackage
`default_nettype wire

// ---- rtl/ssp_smbus_slave.sv ----
// smbus slave with pec: link logic on scl, user side on mclk
// Notes on behaviour
// R1 - answer only to own seven-bit address
// R2 - sda input when receiving, open-drain when sending
// R3 - only the master starts a transaction
// R4 - one bit per scl cycle, sda stable high
// R5 - sda change with scl high is start/stop
// R6 - stop mid-byte discards it, full bytes commit
// R7 - eight bits msb first, then ack slot
// R8 - hold scl low until read data ready
// R9 - stop returns bus to idle
// R10 - detect start and stop conditions
// R11 - accept repeated start at byte boundary
// R12 - ack: sda low across ninth clock
// R13 - nack: sda released across ninth clock
// R14 - start then stop is no transaction
// R15 - bit after address: one read, zero write
// R16 - byte write acked byte by byte
// R17 - word write low byte first, then pec
// R18 - byte read returns data then pec
// R19 - word read returns low, high, pec
// R20 - framing follows smbus
// R21 - silent on bus while switch fault present; code withholds the address ack, an acked transaction still drives sda
// R22 - pec is crc-8 poly 07, init zero
// R23 - foreign address: release sda, ignore transaction
`default_nettype none
module ssp_smbus_slave #(
  parameter logic [6:0] DEV_ADDR = ssp_pkg::DEV_ADDR_DEF
) (
  // system clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // two-wire link
  input  wire logic             scl_clk,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  output logic                  scl_o,
  output logic                  scl_oe,
  // protection switch state pins
  input  wire logic             charge_switch_open,
  input  wire logic             discharge_switch_open,
  // committed writes
  output logic                  wr_valid,
  output ssp_pkg::ssp_wr_t      wr_data,
  output logic                  pec_error,
  // read fetch
  output logic                  rd_req,
  output logic [7:0]            rd_cmd,
  input  wire logic             rd_valid,
  input  wire ssp_pkg::ssp_rd_t rd_rsp
);

  // crc-8 step over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ ssp_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // own address compare
  function automatic logic addr_hit(input logic [6:0] a);
    return a == DEV_ADDR;
  endfunction

  // byte to send at a given position of a read
  function automatic logic [7:0] tx_pick(input logic [1:0] idx, input ssp_pkg::ssp_rd_t r,
                                         input logic [7:0] c);
    case (idx)
      ssp_pkg::TX_LO:       return r.data[7:0];
      ssp_pkg::TX_HI:       return r.is_word ? r.data[15:8] : c;
      ssp_pkg::TX_PEC_WORD: return r.is_word ? c : ssp_pkg::TX_IDLE_BYTE;
      default:              return ssp_pkg::TX_IDLE_BYTE;
    endcase
  endfunction

  logic                rst_link_q;
  logic                stop_d_q;
  logic                stop_tog_q;
  logic [7:0]          shreg_q;
  logic                sda_hi_q;
  logic                ack_q;
  logic [1:0]          flt_l_q;
  logic                fault_l;
  logic                stop_seen_q;
  logic                start_w;
  logic                addr_ok;
  ssp_pkg::ssp_state_t state_q;
  logic [3:0]          bit_q;
  logic                dir_q;
  logic                hit_q;
  logic [2:0]          wr_cnt_q;
  logic [7:0]          cmd_q;
  logic [15:0]         data_q;
  logic                pec_ok_q;
  logic [7:0]          crc_q;
  logic                rd_tog_q;
  logic                sda_oe_q;
  logic [7:0]          tx_sh_q;
  logic [7:0]          tx_cur_q;
  logic [1:0]          tx_idx_q;
  logic [1:0]          tx_sel;
  logic [7:0]          tx_next;
  logic [3:0]          s1_q;
  logic [3:0]          s2_q;
  logic                fault_q;
  logic                tog_d_q;
  logic                pend_q;
  ssp_pkg::ssp_rd_t    rd_q;
  ssp_pkg::ssp_wr_t    wr_q;
  logic                wr_valid_q;
  logic                pec_error_q;
  logic                rd_req_q;
  logic [7:0]          rd_cmd_q;

  // reset for the link flops, taken from the mclk side while scl is idle
  always_ff @(posedge mclk) begin
    rst_link_q <= reset;
  end

  // stop: sda rises while scl high; flips a toggle that both sides compare
  // a toggle keeps the stop visible to the next start however late it comes
  always_ff @(posedge sda_i or posedge rst_link_q) begin
    if (rst_link_q) begin
      stop_tog_q <= 1'b0;
    end else if (scl_clk) begin
      stop_tog_q <= ~stop_tog_q; // R5 R10 R9
    end
  end

  // rising scl: sample the data line, msb first
  always_ff @(posedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      shreg_q  <= ssp_pkg::BYTE_ZERO;
      sda_hi_q <= 1'b1;
      ack_q    <= 1'b1;
    end else begin
      shreg_q  <= {shreg_q[6:0], sda_i}; // R7 R4
      sda_hi_q <= sda_i;
      if (bit_q == ssp_pkg::BIT_ACK) begin
        ack_q <= sda_i; // R12 R13
      end
    end
  end

  // fault level into the link domain
  always_ff @(posedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      flt_l_q <= 2'h0;
    end else begin
      flt_l_q <= {flt_l_q[0], fault_q};
    end
  end
  assign fault_l = flt_l_q[1];

  // start seen at falling scl: sda was high at rise, or a stop came since the last fall
  // the stop toggle is static for many scl periods here, so no extra sampling
  assign start_w = ~sda_i & (sda_hi_q | (stop_tog_q ^ stop_seen_q)); // R5 R10 R11
  assign addr_ok = addr_hit(shreg_q[7:1]) & ~fault_l; // R1 R21 R23

  // each falling scl consumes the stops seen so far, so a stop opens one start only
  always_ff @(negedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      stop_seen_q <= 1'b0;
    end else begin
      stop_seen_q <= stop_tog_q;
    end
  end

  // protocol state and bit counter
  always_ff @(negedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      state_q <= ssp_pkg::ST_IDLE;
      bit_q   <= ssp_pkg::BIT_FIRST;
      dir_q   <= 1'b0;
      hit_q   <= 1'b0;
    end else if (start_w) begin
      state_q <= ssp_pkg::ST_ADDR; // R10 R11 R3 R20
      bit_q   <= ssp_pkg::BIT_FIRST;
    end else if (state_q != ssp_pkg::ST_IDLE) begin
      bit_q <= (bit_q == ssp_pkg::BIT_ACK) ? ssp_pkg::BIT_FIRST : bit_q + ssp_pkg::BIT_STEP; // R7
      if (bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_ADDR) begin
        hit_q <= addr_ok; // R1
        dir_q <= shreg_q[0]; // R15
      end
      if (bit_q == ssp_pkg::BIT_ACK) begin
        case (state_q)
          ssp_pkg::ST_ADDR: state_q <= !hit_q ? ssp_pkg::ST_IGNORE : // R23
                                       (dir_q ? ssp_pkg::ST_RD : ssp_pkg::ST_WR); // R15
          ssp_pkg::ST_RD: begin
            if (ack_q) begin
              state_q <= ssp_pkg::ST_IGNORE; // R13
            end
          end
          default: ;
        endcase
      end
    end
  end

  // received bytes, crc and read prefetch
  always_ff @(negedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      wr_cnt_q <= ssp_pkg::IDX_CMD;
      cmd_q    <= ssp_pkg::BYTE_ZERO;
      data_q   <= 16'h0000;
      pec_ok_q <= 1'b0;
      crc_q    <= ssp_pkg::CRC_INIT;
      rd_tog_q <= 1'b0;
    end else if (start_w) begin
      wr_cnt_q <= ssp_pkg::IDX_CMD; // R14 R6
    end else if (bit_q == ssp_pkg::BIT_LAST) begin
      case (state_q)
        ssp_pkg::ST_ADDR: begin
          if (addr_ok) begin
            crc_q <= crc8(shreg_q[0] ? crc_q : ssp_pkg::CRC_INIT, shreg_q); // R22
          end
        end
        ssp_pkg::ST_WR: begin
          crc_q    <= crc8(crc_q, shreg_q); // R22
          pec_ok_q <= (shreg_q == crc_q);
          if (wr_cnt_q != ssp_pkg::CNT_MAX) begin
            wr_cnt_q <= wr_cnt_q + ssp_pkg::CNT_STEP; // R6
          end
          if (wr_cnt_q == ssp_pkg::IDX_CMD) begin
            cmd_q    <= shreg_q;
            rd_tog_q <= ~rd_tog_q; // R18 R19
          end
          if (wr_cnt_q == ssp_pkg::IDX_LO) begin
            data_q[7:0] <= shreg_q; // R17
          end
          if (wr_cnt_q == ssp_pkg::IDX_HI) begin
            data_q[15:8] <= shreg_q; // R17
          end
        end
        ssp_pkg::ST_RD: crc_q <= crc8(crc_q, tx_cur_q); // R22
        default: ;
      endcase
    end
  end

  // next byte to send; rd_q is static since the prefetch ended
  assign tx_sel  = (state_q == ssp_pkg::ST_ADDR) ? ssp_pkg::TX_LO : tx_idx_q;
  assign tx_next = tx_pick(tx_sel, rd_q, crc_q);

  // sda drive: ack slots and transmitted bits, changed with scl low
  always_ff @(negedge scl_clk or posedge rst_link_q) begin
    if (rst_link_q) begin
      sda_oe_q <= 1'b0;
      tx_sh_q  <= ssp_pkg::TX_IDLE_BYTE;
      tx_cur_q <= ssp_pkg::TX_IDLE_BYTE;
      tx_idx_q <= ssp_pkg::TX_LO;
    end else if (start_w) begin
      sda_oe_q <= 1'b0;
    end else begin
      case (bit_q)
        ssp_pkg::BIT_LAST: begin
          sda_oe_q <= (state_q == ssp_pkg::ST_ADDR && addr_ok) || // R12 R23
                      state_q == ssp_pkg::ST_WR; // R16 R17
        end
        ssp_pkg::BIT_ACK: begin
          if ((state_q == ssp_pkg::ST_ADDR && hit_q && dir_q) ||
              (state_q == ssp_pkg::ST_RD && !ack_q)) begin
            tx_sh_q  <= tx_next; // R18 R19
            tx_cur_q <= tx_next;
            sda_oe_q <= ~tx_next[7]; // R2 R7
            if (state_q == ssp_pkg::ST_ADDR) begin
              tx_idx_q <= ssp_pkg::TX_HI;
            end else if (tx_idx_q != ssp_pkg::TX_END) begin
              tx_idx_q <= tx_idx_q + ssp_pkg::TX_STEP;
            end
          end else begin
            sda_oe_q <= 1'b0;
          end
        end
        default: begin
          if (state_q == ssp_pkg::ST_RD) begin
            tx_sh_q  <= {tx_sh_q[6:0], 1'b1};
            sda_oe_q <= ~tx_sh_q[6]; // R2 R4
          end else begin
            sda_oe_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // pins and link events into mclk
  always_ff @(posedge mclk) begin
    s1_q <= {charge_switch_open, discharge_switch_open, stop_tog_q, rd_tog_q};
    s2_q <= s1_q;
  end

  // fault level gates the address ack, commits and read fetches
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= s2_q[3] | s2_q[2]; // R21
    end
  end

  // commit a complete write at stop; link words are static meanwhile
  always_ff @(posedge mclk) begin
    if (reset) begin
      stop_d_q    <= 1'b0;
      wr_valid_q  <= 1'b0;
      pec_error_q <= 1'b0;
      wr_q        <= '0;
    end else begin
      stop_d_q    <= s2_q[1];
      wr_valid_q  <= 1'b0;
      pec_error_q <= 1'b0;
      if ((s2_q[1] != stop_d_q) && !dir_q && !fault_q &&
          (wr_cnt_q == ssp_pkg::CNT_BYTE_WR || wr_cnt_q == ssp_pkg::CNT_WORD_WR)) begin
        wr_valid_q      <= pec_ok_q; // R6 R16 R17 R22
        pec_error_q     <= ~pec_ok_q;
        wr_q.cmd        <= cmd_q;
        wr_q.is_word    <= (wr_cnt_q == ssp_pkg::CNT_WORD_WR);
        wr_q.data       <= (wr_cnt_q == ssp_pkg::CNT_WORD_WR) ? data_q :
                           {ssp_pkg::BYTE_ZERO, data_q[7:0]};
      end
    end
  end

  // read prefetch after each command byte; scl held low until answered
  always_ff @(posedge mclk) begin
    if (reset) begin
      tog_d_q  <= 1'b0;
      pend_q   <= 1'b0;
      rd_req_q <= 1'b0;
      rd_cmd_q <= ssp_pkg::BYTE_ZERO;
      rd_q     <= '0;
    end else begin
      tog_d_q  <= s2_q[0];
      rd_req_q <= 1'b0;
      if (pend_q && rd_valid) begin
        rd_q   <= rd_rsp;
        pend_q <= 1'b0;
      end
      if (s2_q[0] != tog_d_q && !fault_q) begin
        rd_req_q <= 1'b1;
        rd_cmd_q <= cmd_q;
        pend_q   <= 1'b1; // R8
      end else if (fault_q) begin
        pend_q <= 1'b0; // R21
      end
    end
  end

  // outputs; both lines only ever pulled low
  assign sda_o     = 1'b0;
  assign sda_oe    = sda_oe_q;
  assign scl_o     = 1'b0;
  assign scl_oe    = pend_q;
  assign wr_valid  = wr_valid_q;
  assign wr_data   = wr_q;
  assign pec_error = pec_error_q;
  assign rd_req    = rd_req_q;
  assign rd_cmd    = rd_cmd_q;

  // checks on the link domain
  property p_ack_match;
    @(negedge scl_clk) disable iff (rst_link_q)
    (!start_w && bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_ADDR && addr_ok)
      |=> sda_oe_q ##1 !sda_oe_q || state_q == ssp_pkg::ST_RD;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("own address not acked"); // R1

  property p_foreign;
    @(negedge scl_clk) disable iff (rst_link_q)
    (!start_w && bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_ADDR && !addr_ok)
      |=> !sda_oe_q ##1 (state_q == ssp_pkg::ST_IGNORE || $past(start_w));
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address not ignored"); // R23

  property p_start;
    @(negedge scl_clk) disable iff (rst_link_q)
    start_w |=> state_q == ssp_pkg::ST_ADDR && bit_q == ssp_pkg::BIT_FIRST && !sda_oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start did not restart frame"); // R10

  property p_bits;
    @(negedge scl_clk) disable iff (rst_link_q)
    (!start_w && state_q != ssp_pkg::ST_IDLE && bit_q != ssp_pkg::BIT_ACK)
      |=> bit_q == $past(bit_q) + ssp_pkg::BIT_STEP;
  endproperty
  a_bits: assert property (p_bits) else $error("bit counter skipped"); // R7

  property p_wr_ack;
    @(negedge scl_clk) disable iff (rst_link_q)
    (!start_w && bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_WR)
      |=> sda_oe_q ##1 !sda_oe_q;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte ack wrong"); // R16

  property p_tx_release;
    @(negedge scl_clk) disable iff (rst_link_q)
    (!start_w && bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_RD) |=> !sda_oe_q;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("sda held in master ack"); // R13

  property p_fault_silent;
    @(negedge scl_clk) disable iff (rst_link_q)
    (fault_l && !start_w && bit_q == ssp_pkg::BIT_LAST && state_q == ssp_pkg::ST_ADDR)
      |=> !sda_oe_q;
  endproperty
  a_fault_silent: assert property (p_fault_silent) else $error("acked under fault"); // R21

  // checks on the mclk domain
  property p_commit_stop;
    @(posedge mclk) disable iff (reset)
    (wr_valid_q || pec_error_q) |-> $past(s2_q[1]) != $past(stop_d_q);
  endproperty
  a_commit_stop: assert property (p_commit_stop) else $error("commit without stop"); // R6

  property p_pec_excl;
    @(posedge mclk) disable iff (reset)
    pec_error_q |-> !wr_valid_q ##1 !wr_valid_q;
  endproperty
  a_pec_excl: assert property (p_pec_excl) else $error("bad pec committed"); // R22

  property p_stretch;
    @(posedge mclk) disable iff (reset)
    (pend_q && !rd_valid && !fault_q) |=> pend_q && scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl released early"); // R8

  // main scenarios
  c_word_wr: cover property (@(posedge mclk) disable iff (reset) wr_valid_q && wr_q.is_word);
  c_pec_err: cover property (@(posedge mclk) disable iff (reset) pec_error_q);
  c_stretch: cover property (@(posedge mclk) disable iff (reset) pend_q [*3]);
  c_read: cover property (@(negedge scl_clk) disable iff (rst_link_q)
                          state_q == ssp_pkg::ST_RD && tx_idx_q == ssp_pkg::TX_END);

endmodule
`default_nettype wire

// ---- testbench/ssp_host_model.sv ----
// smbus master model driving scl and sda towards the slave
`default_nettype none
module ssp_host_model (
  // slave pin drivers
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // resolved wire levels
  output wire logic scl_line,
  output wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_m;
  logic sda_m;
  int   stall_err;
  // open-drain wires with pull-ups
  assign scl_line = scl_m & ~scl_oe;
  assign sda_line = sda_m & ~sda_oe;
  // bus idle, master only acts when a task is called
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stall_err = 0;
  end
  // release scl, then wait while the slave stretches
  task automatic scl_up();
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl_line !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
    if (n >= 4000) stall_err++;
  endtask
  // start or repeated start
  task automatic start();
    sda_m = 1'b1;
    #4;
    scl_up();
    #7.5;
    sda_m = 1'b0;
    #7.5;
    scl_m = 1'b0;
    #4;
  endtask
  // one bit, sda held still while scl is high
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #4;
    scl_up();
    #7.5;
    r = sda_line;
    scl_m = 1'b0;
    #3.5;
  endtask
  // eight bits msb first then the ack slot; scl then rests low
  task automatic byte_io(input logic [7:0] tx, input logic nack, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(nack, r);
    ack = ~r;
    sda_m = 1'b1;
    #1000;
  endtask
  // stop, then the gap the slave needs before a new start
  task automatic stop();
    sda_m = 1'b0;
    #4;
    scl_up();
    #7.5;
    sda_m = 1'b1;
    #1000;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the smbus slave with pec
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = ssp_pkg::DEV_ADDR_DEF;
  logic             mclk, reset, chg_open, dsg_open, rd_valid, rd_w, fault;
  logic             scl_line, sda_line, sda_o, sda_oe, scl_o, scl_oe;
  logic             wr_valid, pec_error, rd_req;
  logic [7:0]       rd_cmd;
  ssp_pkg::ssp_wr_t wr_data, wr_last;
  ssp_pkg::ssp_rd_t rd_rsp;
  int               miscompares, total_checks, wr_cnt, pec_cnt, req_cnt, cyc, rsp_dly, evt0;

  ssp_smbus_slave #(.DEV_ADDR(ADDR)) u_dut (
    .mclk(mclk), .reset(reset), .scl_clk(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
    .charge_switch_open(chg_open), .discharge_switch_open(dsg_open),
    .wr_valid(wr_valid), .wr_data(wr_data), .pec_error(pec_error),
    .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(rd_valid), .rd_rsp(rd_rsp)
  );
  ssp_host_model u_host (
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line)
  );

  // system clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // user side answers each fetch after a chosen delay
  initial begin
    rd_valid = 1'b0;
    rd_rsp = '0;
    forever begin
      @(posedge mclk);
      if (rd_req === 1'b1) begin
        repeat (rsp_dly) @(posedge mclk);
        #2;
        rd_valid = 1'b1;
        rd_rsp = '{data: rd_word(rd_cmd), is_word: rd_w};
        repeat (3) @(posedge mclk);
        #2;
        rd_valid = 1'b0;
      end
    end
  end

  // count user side pulses and cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1) wr_cnt <= wr_cnt + 1;
    if (wr_valid === 1'b1) wr_last <= wr_data;
    if (pec_error === 1'b1) pec_cnt <= pec_cnt + 1;
    if (rd_req === 1'b1) req_cnt <= req_cnt + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  function automatic logic [7:0] crc_add(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? (c << 1) ^ ssp_pkg::CRC_POLY : c << 1;
    return c;
  endfunction

  // read data the user side returns for a command
  function automatic logic [15:0] rd_word(logic [7:0] cmd);
    return {cmd ^ 8'hA5, ~cmd};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // write byte or word with pec; optional bad pec and four stray bits after the pec byte
  task automatic write_txn(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
                           input logic word, input logic bad, input logic cut);
    logic [7:0] q[$];
    logic [7:0] pec, rx;
    logic       ak, ok;
    int         w0, p0, r0;
    w0 = wr_cnt;
    p0 = pec_cnt;
    r0 = req_cnt;
    ok = (a == ADDR) && !fault;
    q = '{{a, 1'b0}, cmd, d[7:0]};
    if (word) q.push_back(d[15:8]);
    pec = ssp_pkg::CRC_INIT;
    foreach (q[i]) pec = crc_add(pec, q[i]);
    q.push_back(pec ^ {7'h00, bad});
    u_host.start();
    foreach (q[i]) begin
      u_host.byte_io(q[i], 1'b1, rx, ak);
      check(ak, ok, "write ack");
    end
    for (int i = 0; i < 4; i++) if (cut) u_host.bit_io(1'b0, ak);
    u_host.stop();
    repeat (8) @(posedge mclk);
    check(wr_cnt - w0, ok && !bad, "commit count");
    check(pec_cnt - p0, ok && bad, "pec error count");
    check(req_cnt - r0, ok, "fetch count");
    if (ok && !bad) check(wr_last, {cmd, word ? d : {8'h00, d[7:0]}, word}, "data");
    check({sda_o, scl_o, sda_oe, scl_oe}, 4'h0, "bus released");
  endtask

  // read byte or word after a repeated start; extra reads one byte past the pec
  task automatic read_txn(input logic [7:0] cmd, input logic word, input logic extra);
    logic [7:0]  pec, rx, ex;
    logic [15:0] d;
    logic        ak;
    int          n;
    d = rd_word(cmd);
    n = word ? 2 : 1;
    rd_w = word;
    rsp_dly = $urandom_range(8, 0);
    u_host.start();
    u_host.byte_io({ADDR, 1'b0}, 1'b1, rx, ak);
    u_host.byte_io(cmd, 1'b1, rx, ak);
    check(rd_cmd, cmd, "fetch command");
    u_host.start();
    u_host.byte_io({ADDR, 1'b1}, 1'b1, rx, ak);
    check(ak, 1'b1, "read address ack");
    pec = crc_add(crc_add(crc_add(ssp_pkg::CRC_INIT, {ADDR, 1'b0}), cmd), {ADDR, 1'b1});
    for (int i = 0; i <= n; i++) begin
      ex = (i == n) ? pec : d[8*i +: 8];
      u_host.byte_io(8'hFF, (i == n) && !extra, rx, ak);
      check(rx, ex, "read byte");
      pec = crc_add(pec, ex);
    end
    if (extra) u_host.byte_io(8'hFF, 1'b1, rx, ak);
    if (extra) check(rx, ssp_pkg::TX_IDLE_BYTE, "byte past pec");
    u_host.stop();
    check({sda_o, scl_o, sda_oe, scl_oe}, 4'h0, "bus released");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(11));
    reset = 1'b1;
    chg_open = 1'b0;
    dsg_open = 1'b0;
    fault = 1'b0;
    rd_w = 1'b0;
    rsp_dly = 0;
    {miscompares, total_checks, wr_cnt, pec_cnt, req_cnt, cyc} = '0;
    repeat (12) @(posedge mclk);
    #2 reset = 1'b0;
    repeat (6) @(posedge mclk);
    write_txn(ADDR, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    write_txn(ADDR, 8'hFF, 16'hFFFF, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++)
      write_txn(ADDR, 8'($urandom), 16'($urandom), 1'($urandom), 1'b0, 1'b0);
    $display("test writes done");
    write_txn(ADDR, 8'h12, 16'h3456, 1'b1, 1'b1, 1'b0);
    write_txn(ADDR, 8'h34, 16'h0078, 1'b0, 1'b1, 1'b0);
    write_txn(ADDR, 8'h21, 16'h0043, 1'b0, 1'b0, 1'b1);
    write_txn(ADDR ^ 7'h01, 8'h05, 16'h0102, 1'b1, 1'b0, 1'b0);
    $display("test errors done");
    evt0 = wr_cnt + req_cnt + pec_cnt;
    u_host.start();
    u_host.stop();
    repeat (8) @(posedge mclk);
    check(wr_cnt + req_cnt + pec_cnt, evt0, "start then stop");
    for (int k = 0; k < 6; k++) read_txn(8'($urandom), 1'(k), 1'b0);
    read_txn(8'h00, 1'b0, 1'b1);
    read_txn(8'hFF, 1'b1, 1'b1);
    $display("test reads done");
    @(posedge mclk);
    #2 chg_open = 1'b1;
    fault = 1'b1;
    repeat (4) @(posedge mclk);
    write_txn(ADDR, 8'h44, 16'h0055, 1'b0, 1'b0, 1'b0);
    #2 {chg_open, dsg_open} = 2'b01;
    repeat (4) @(posedge mclk);
    write_txn(ADDR, 8'h46, 16'h7788, 1'b1, 1'b0, 1'b0);
    #2 dsg_open = 1'b0;
    fault = 1'b0;
    repeat (4) @(posedge mclk);
    write_txn(ADDR, 8'h48, 16'h99AA, 1'b1, 1'b0, 1'b0);
    $display("test fault done");
    check(u_host.stall_err, 0, "stretch bounded");
    final_report();
  end
endmodule
`default_nettype wire
